// >>> core/itci_pkg.sv
// constants and carriers for the interrupt and timer control instruction unit
// assumes one clock, synchronous reset and a 32-bit AXI4-Lite register port

package itci_pkg;

   // ---------------------------------------------------------------
   // data, address and op code widths and the timer control register count
   // ---------------------------------------------------------------
   localparam int DW      = 4;
   localparam int AW      = 8;
   localparam int OPW     = 5;
   localparam int NUM_TCR = 5;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [AW-1:0] ADDR_ACC    = 8'h00;
   localparam logic [AW-1:0] ADDR_OP     = 8'h04;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h08;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int REQ0_MODE_BIT = 0;
   localparam int REQ1_MODE_BIT = 1;
   localparam int PIN_POL_BIT   = 2;
   localparam int ST_GIE        = 0;
   localparam int ST_FLAG0      = 1;
   localparam int ST_FLAG1      = 2;
   localparam int ST_SKIP       = 3;
   localparam int ST_PIN0       = 4;
   localparam int ST_PIN1       = 5;

   // ---------------------------------------------------------------
   // values after reset and bus answers
   // ---------------------------------------------------------------
   localparam logic [DW-1:0] RST_NIBBLE = 4'h0;
   localparam logic          RST_BIT    = 1'b0;
   localparam logic [1:0]    RESP_OKAY  = 2'h0;
   localparam logic [1:0]    RESP_SLV   = 2'h2;

   // ---------------------------------------------------------------
   // operation codes written to the op register
   // ---------------------------------------------------------------
   localparam logic [OPW-1:0] OP_CLR_IE    = 5'h00;
   localparam logic [OPW-1:0] OP_SET_IE    = 5'h01;
   localparam logic [OPW-1:0] OP_SKIP_REQ0 = 5'h02;
   localparam logic [OPW-1:0] OP_SKIP_REQ1 = 5'h03;
   localparam logic [OPW-1:0] OP_SKIP_PIN0 = 5'h04;
   localparam logic [OPW-1:0] OP_SKIP_PIN1 = 5'h05;
   localparam logic [OPW-1:0] OP_RD_ICR1   = 5'h06;
   localparam logic [OPW-1:0] OP_WR_ICR1   = 5'h07;
   localparam logic [OPW-1:0] OP_RD_ICR2   = 5'h08;
   localparam logic [OPW-1:0] OP_WR_ICR2   = 5'h09;
   localparam logic [OPW-1:0] OP_RD_INP1   = 5'h0A;
   localparam logic [OPW-1:0] OP_WR_INP1   = 5'h0B;
   localparam logic [OPW-1:0] OP_RD_INP2   = 5'h0C;
   localparam logic [OPW-1:0] OP_WR_INP2   = 5'h0D;
   localparam logic [OPW-1:0] OP_WR_TPORT  = 5'h0E;
   localparam logic [OPW-1:0] OP_RD_TCR1   = 5'h0F;
   localparam logic [OPW-1:0] OP_WR_TCR1   = 5'h14;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [DW-1:0]              icr1;
      logic [DW-1:0]              icr2;
      logic [DW-1:0]              inp1;
      logic [DW-1:0]              inp2;
      logic                       tport;
      logic [NUM_TCR-1:0][DW-1:0] tcr;
   } itci_ctl_t;

   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } itci_wr_state_t;

endpackage

// >>> core/itci_core.sv
// interrupt and timer control instruction unit, driven over AXI4-Lite
// assumes inputs synchronous to aclk; request events arrive as one-cycle pulses

`timescale 1ns/1ns

module itci_core (
   // clock, reset, enable
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic                        ce,
   // axi4-lite write address and data
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [itci_pkg::AW-1:0]     s_axi_awaddr,
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   // axi4-lite write response
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output      logic [1:0]                  s_axi_bresp,
   // axi4-lite read
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   input  wire logic [itci_pkg::AW-1:0]     s_axi_araddr,
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output      logic [31:0]                 s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   // external interrupt side
   input  wire logic                        ext_pin_zero,
   input  wire logic                        ext_pin_one,
   input  wire logic                        ext_req_set_zero,
   input  wire logic                        ext_req_set_one,
   // state seen by the rest of the core
   output      logic                        global_int_enable,
   output      logic                        ext_req_flag_zero,
   output      logic                        ext_req_flag_one,
   output      logic                        skip_pending,
   output      logic                        op_done,
   output      itci_pkg::itci_ctl_t         ctl
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [1:0] addr_sel(input logic [itci_pkg::AW-1:0] a);
      case (a)
         itci_pkg::ADDR_ACC:    return 2'h0;
         itci_pkg::ADDR_OP:     return 2'h1;
         itci_pkg::ADDR_STATUS: return 2'h2;
         default:               return 2'h3;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   itci_pkg::itci_wr_state_t    wr_state_r;
   logic                        aw_have_r;
   logic                        w_have_r;
   logic [itci_pkg::AW-1:0]     aw_addr_r;
   logic [itci_pkg::DW-1:0]     w_data_r;
   logic                        w_lane0_r;
   logic [itci_pkg::OPW-1:0]    w_op_r;
   logic [itci_pkg::DW-1:0]     acc_r;
   logic [itci_pkg::OPW-1:0]    last_op_r;
   logic                        skip_r;
   logic                        gie_r;
   logic                        flag0_r;
   logic                        flag1_r;
   itci_pkg::itci_ctl_t         ctl_r;

   // ---------------------------------------------------------------
   // combinational execution
   // ---------------------------------------------------------------
   logic                        wr_fire;
   logic                        exec_go;
   logic                        exec_run;
   logic [itci_pkg::OPW-1:0]    op;
   logic                        acc_load;
   logic [itci_pkg::DW-1:0]     acc_val;
   logic                        skip_take;
   logic                        gie_nxt;
   logic                        clr0;
   logic                        clr1;
   logic                        skip0_cond;
   logic                        skip1_cond;
   itci_pkg::itci_ctl_t         ctl_nxt;
   logic [itci_pkg::OPW-1:0]    tcr_rd_idx;
   logic [itci_pkg::OPW-1:0]    tcr_wr_idx;

   assign wr_fire   = (wr_state_r == itci_pkg::WR_IDLE) && aw_have_r && w_have_r;
   assign exec_go   = ce && wr_fire && w_lane0_r && (addr_sel(aw_addr_r) == 2'h1);
   // a suppressed op still consumes the pending skip
   assign exec_run  = exec_go && !skip_r;
   assign op        = w_op_r;
   assign tcr_rd_idx = op - itci_pkg::OP_RD_TCR1;
   assign tcr_wr_idx = op - itci_pkg::OP_WR_TCR1;
   assign skip0_cond = !ctl_r.icr1[itci_pkg::REQ0_MODE_BIT] && flag0_r;
   assign skip1_cond = !ctl_r.icr1[itci_pkg::REQ1_MODE_BIT] && flag1_r;

   always_comb begin
      acc_load  = 1'b0;
      acc_val   = acc_r;
      skip_take = 1'b0;
      gie_nxt   = gie_r;
      clr0      = 1'b0;
      clr1      = 1'b0;
      ctl_nxt   = ctl_r;
      case (op)
         itci_pkg::OP_CLR_IE:   gie_nxt = 1'b0;
         itci_pkg::OP_SET_IE:   gie_nxt = 1'b1;
         itci_pkg::OP_SKIP_REQ0: begin
            skip_take = skip0_cond;
            clr0      = skip0_cond;
         end
         itci_pkg::OP_SKIP_REQ1: begin
            skip_take = skip1_cond;
            clr1      = skip1_cond;
         end
         itci_pkg::OP_SKIP_PIN0:
            skip_take = (ext_pin_zero == ctl_r.inp1[itci_pkg::PIN_POL_BIT]);
         itci_pkg::OP_SKIP_PIN1:
            skip_take = (ext_pin_one == ctl_r.inp2[itci_pkg::PIN_POL_BIT]);
         itci_pkg::OP_RD_ICR1: begin
            acc_load = 1'b1;
            acc_val  = ctl_r.icr1;
         end
         itci_pkg::OP_WR_ICR1:  ctl_nxt.icr1 = acc_r;
         itci_pkg::OP_RD_ICR2: begin
            acc_load = 1'b1;
            acc_val  = ctl_r.icr2;
         end
         itci_pkg::OP_WR_ICR2:  ctl_nxt.icr2 = acc_r;
         itci_pkg::OP_RD_INP1: begin
            acc_load = 1'b1;
            acc_val  = ctl_r.inp1;
         end
         itci_pkg::OP_WR_INP1:  ctl_nxt.inp1 = acc_r;
         itci_pkg::OP_RD_INP2: begin
            acc_load = 1'b1;
            acc_val  = ctl_r.inp2;
         end
         itci_pkg::OP_WR_INP2:  ctl_nxt.inp2 = acc_r;
         itci_pkg::OP_WR_TPORT: ctl_nxt.tport = acc_r[0];
         default: begin
            // timer controls sit on two runs of consecutive codes
            if (tcr_rd_idx < 5'(itci_pkg::NUM_TCR)) begin
               acc_load = 1'b1;
               acc_val  = ctl_r.tcr[tcr_rd_idx[2:0]];
            end else if (tcr_wr_idx < 5'(itci_pkg::NUM_TCR)) begin
               ctl_nxt.tcr[tcr_wr_idx[2:0]] = acc_r;
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // axi write channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r     <= 1'b0;
         aw_addr_r     <= '0;
         s_axi_awready <= 1'b0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end else if (!aw_have_r && wr_state_r == itci_pkg::WR_IDLE) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r     <= 1'b0;
         w_data_r     <= itci_pkg::RST_NIBBLE;
         w_op_r       <= '0;
         w_lane0_r    <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r     <= 1'b1;
            w_data_r     <= s_axi_wdata[itci_pkg::DW-1:0];
            w_op_r       <= s_axi_wdata[itci_pkg::OPW-1:0];
            w_lane0_r    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end else if (!w_have_r && wr_state_r == itci_pkg::WR_IDLE) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r   <= itci_pkg::WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= itci_pkg::RESP_OKAY;
      end else if (ce) begin
         case (wr_state_r)
            itci_pkg::WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_r   <= itci_pkg::WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= (addr_sel(aw_addr_r) == 2'h3) ? itci_pkg::RESP_SLV
                                                                : itci_pkg::RESP_OKAY;
               end
            end
            itci_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_r   <= itci_pkg::WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: wr_state_r <= itci_pkg::WR_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // axi read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= itci_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= itci_pkg::RESP_OKAY;
            case (addr_sel(s_axi_araddr))
               2'h0: s_axi_rdata <= {28'h000_0000, acc_r};
               2'h1: s_axi_rdata <= {27'h0, last_op_r};
               2'h2: s_axi_rdata <= {26'h0, ext_pin_one, ext_pin_zero,
                                     skip_r, flag1_r, flag0_r, gie_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= itci_pkg::RESP_SLV;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // accumulator and op bookkeeping
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_r     <= itci_pkg::RST_NIBBLE;
         last_op_r <= '0;
         op_done   <= 1'b0;
      end else if (ce) begin
         op_done <= exec_go;
         if (exec_go) begin
            last_op_r <= op;
         end
         if (exec_run && acc_load) begin
            acc_r <= acc_val;
         end else if (wr_fire && w_lane0_r && addr_sel(aw_addr_r) == 2'h0) begin
            acc_r <= w_data_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // skip, enable and control registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_r <= itci_pkg::RST_BIT;
         gie_r  <= itci_pkg::RST_BIT;
         ctl_r  <= '0;
      end else if (ce && exec_go) begin
         // a suppressed op never arms a further skip
         skip_r <= exec_run && skip_take;
         if (exec_run) begin
            gie_r <= gie_nxt;
            ctl_r <= ctl_nxt;
         end
      end
   end

   // request flags: a set in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag0_r <= itci_pkg::RST_BIT;
         flag1_r <= itci_pkg::RST_BIT;
      end else if (ce) begin
         if (ext_req_set_zero) begin
            flag0_r <= 1'b1;
         end else if (exec_run && clr0) begin
            flag0_r <= 1'b0;
         end
         if (ext_req_set_one) begin
            flag1_r <= 1'b1;
         end else if (exec_run && clr1) begin
            flag1_r <= 1'b0;
         end
      end
   end

   assign global_int_enable = gie_r;
   assign ext_req_flag_zero = flag0_r;
   assign ext_req_flag_one  = flag1_r;
   assign skip_pending      = skip_r;
   assign ctl               = ctl_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   clr_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_CLR_IE |=> !global_int_enable)
      else $error("enable not cleared");
   set_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SET_IE |=> global_int_enable)
      else $error("enable not set");
   req0_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_REQ0 |=> skip_pending == $past(skip0_cond))
      else $error("request zero skip wrong");
   req0_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_REQ0 && skip0_cond && !ext_req_set_zero
      |=> !ext_req_flag_zero && skip_pending)
      else $error("request zero flag kept");
   req0_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_REQ0 && ctl.icr1[0] && !ext_req_set_zero
      |=> !skip_pending && ext_req_flag_zero == $past(ext_req_flag_zero))
      else $error("request zero nop broken");
   req1_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_REQ1 |=> skip_pending == $past(skip1_cond))
      else $error("request one skip wrong");
   req1_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_REQ1 && skip1_cond && !ext_req_set_one
      |=> !ext_req_flag_one)
      else $error("request one flag kept");
   req1_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_REQ1 && ctl.icr1[1] |=> !skip_pending)
      else $error("request one nop broken");
   pin0_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_PIN0
      |=> skip_pending == ($past(ext_pin_zero) == $past(ctl.inp1[2])))
      else $error("pin zero skip wrong");
   pin1_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_SKIP_PIN1
      |=> skip_pending == ($past(ext_pin_one) == $past(ctl.inp2[2])))
      else $error("pin one skip wrong");
   rd_icr1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_RD_ICR1 |=> acc_r == $past(ctl.icr1))
      else $error("icr1 read wrong");
   wr_icr1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_WR_ICR1 |=> ctl.icr1 == $past(acc_r))
      else $error("icr1 write wrong");
   tport_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_run && op == itci_pkg::OP_WR_TPORT |=> ctl.tport == $past(acc_r[0]))
      else $error("timer port load wrong");
   suppress_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_go && skip_pending |=> !skip_pending && ctl == $past(ctl) && acc_r == $past(acc_r)
      && global_int_enable == $past(global_int_enable))
      else $error("skipped op took effect");

endmodule

// >>> core/itci_tail_note_unused.sv
// holds no logic; every design module lives in itci_core.sv

// >>> test/interrupt_timer_ctrl_instr_tb.sv
// self-checking bench for the interrupt and timer control instruction unit
// assumes itci_pkg and itci_core; the bench is the only AXI4-Lite master
`timescale 1ns/1ns
module interrupt_timer_ctrl_instr_tb;
   // ----------
   // signals
   // ----------
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, pin0 = 1'b0, pin1 = 1'b0, set0 = 1'b0, set1 = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, gie, flag0, flag1, skp, opd;
   logic [4:0]  wo, ro;
   logic [3:0]  vals [9] = '{4'h4, 4'hA, 4'h5, 4'h3, 4'h1, 4'h2, 4'h7, 4'hE, 4'hF};
   itci_pkg::itci_ctl_t ctl;
   int          n_mismatch = 0, n_compared = 0;

   always #50 aclk = ~aclk;

   itci_core u_dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .ext_pin_zero(pin0), .ext_pin_one(pin1), .ext_req_set_zero(set0), .ext_req_set_one(set1),
      .global_int_enable(gie), .ext_req_flag_zero(flag0), .ext_req_flag_one(flag1),
      .skip_pending(skp), .op_done(opd), .ctl(ctl));

   task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // each channel is held until its own ready; a lost answer ends the run
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge aclk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      repeat (40) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      chk("write answer", {bvalid, bresp}, {1'b1, itci_pkg::RESP_OKAY});
      if (!bvalid) tally_and_finish();
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      repeat (40) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      chk("read answer", rvalid, 1'b1);
      if (!rvalid) tally_and_finish();
      dat = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   // op_done stands for the cycle in which the write answer is taken
   task automatic op(input logic [4:0] c);
      wr(itci_pkg::ADDR_OP, {27'h0, c});
      chk("op done", opd, 1'b1);
   endtask
   task automatic acc(input logic [3:0] v);
      wr(itci_pkg::ADDR_ACC, {28'h0, v});
      chk("acc write no op", opd, 1'b0);
   endtask

   task automatic pulse(input logic a, input logic b);
      @(posedge aclk);
      set0 <= a;
      set1 <= b;
      @(posedge aclk);
      set0 <= 1'b0;
      set1 <= 1'b0;
   endtask

   // ----------
   // sequence
   // ----------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(itci_pkg::ADDR_STATUS, d, r);
      chk("status after reset", d, '0);
      chk("ctl after reset", ctl, '0);
      $display("reset test done");
      for (int k = 0; k < 9; k++) begin
         wo = (k < 4) ? itci_pkg::OP_WR_ICR1 + 5'(2 * k) : itci_pkg::OP_WR_TCR1 + 5'(k - 4);
         ro = (k < 4) ? wo - 5'h01 : itci_pkg::OP_RD_TCR1 + 5'(k - 4);
         acc(vals[k]);
         op(wo);
         acc(4'h0);
         op(ro);
         rd(itci_pkg::ADDR_ACC, d, r);
         chk("acc", d, {28'h0, vals[k]});
      end
      acc(4'h1);
      op(itci_pkg::OP_WR_TPORT);
      chk("ctl", ctl, {vals[0], vals[1], vals[2], vals[3], 1'b1,
                       vals[8], vals[7], vals[6], vals[5], vals[4]});
      op(itci_pkg::OP_SET_IE);
      chk("gie set", gie, 1'b1);
      op(itci_pkg::OP_CLR_IE);
      chk("gie clear", gie, 1'b0);
      $display("transfer test done");
      pulse(1'b1, 1'b0);
      op(itci_pkg::OP_SKIP_REQ0);
      chk("req0 skip", {skp, flag0}, 2'b10);
      op(itci_pkg::OP_SET_IE);
      chk("suppressed op", {skp, gie}, 2'b00);
      op(itci_pkg::OP_SET_IE);
      chk("op after skip", gie, 1'b1);
      op(itci_pkg::OP_SKIP_REQ0);
      chk("req0 flag low", skp, 1'b0);
      acc(4'h3);
      op(itci_pkg::OP_WR_ICR1);
      pulse(1'b1, 1'b1);
      op(itci_pkg::OP_SKIP_REQ0);
      chk("req0 mode nop", {skp, flag0}, 2'b01);
      op(itci_pkg::OP_SKIP_REQ1);
      chk("req1 mode nop", {skp, flag1}, 2'b01);
      acc(4'h0);
      op(itci_pkg::OP_WR_ICR1);
      op(itci_pkg::OP_SKIP_REQ1);
      chk("req1 skip", {skp, flag1}, 2'b10);
      op(itci_pkg::OP_CLR_IE);
      $display("request skip test done");
      for (int p = 0; p < 4; p++) begin
         acc({1'b0, p[1], 2'b00});
         op(itci_pkg::OP_WR_INP1);
         op(itci_pkg::OP_WR_INP2);
         pin0 <= p[0];
         pin1 <= p[0];
         op(itci_pkg::OP_SKIP_PIN0);
         chk("pin0 skip", skp, p[1] == p[0]);
         op(itci_pkg::OP_CLR_IE);
         op(itci_pkg::OP_SKIP_PIN1);
         chk("pin1 skip", skp, p[1] == p[0]);
         op(itci_pkg::OP_CLR_IE);
      end
      $display("pin skip test done");
      pin0 <= 1'b0;
      pin1 <= 1'b0;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("ctl after mid reset", ctl, '0);
      rd(itci_pkg::ADDR_STATUS, d, r);
      chk("status after mid reset", d, '0);
      rd(itci_pkg::ADDR_ACC, d, r);
      chk("acc after mid reset", d, '0);
      $display("mid reset test done");
      rd(8'h0C, d, r);
      chk("unmapped read", {d, r}, {32'h0000_0000, itci_pkg::RESP_SLV});
      $display("unmapped test done");
      tally_and_finish();
   end
endmodule
